// *** common/kss_pkg.sv ***
// Behaviour
// - key matrix, switch matrix and LEDs share row and column lines by time slots.
// - results and LED states pass through a 128 x 16 dual-port RAM plus registers.
// - new key-on, key-off or switch change raises a service flag naming its key or switch row.
// - processor writes LED states in RAM; scanner drives them row by row alone.
// - key contact interval is measured on a pseudo-logarithmic time scale.
// - up to 16 sliders are converted to 8 bits, selected by row lines.
// - phase select stays high about 1.4 us per row for key matrix access.
// - phase select stays low about 4.3 us per row for switch and LED access.
// - all sequencing is timed from a 354 ns internal scanning clock.
// - key contacts are taken at least 1.2 us after phase rises, before 1.3 us.
// - switch inputs are taken at least 4 us after phase falls, before 4.1 us.
// - sample-and-hold enters follow mode no sooner than 1 us after row change.
// - sample-and-hold switches to hold no later than 2.2 us after row change.
// - three-bit row select steps 0 to 7, about 5.7 us per row.
// - key request stays set until upper byte of reported key word is written.
// - interval counts 0 to 255 in row cycle units, saturating at 255.
// - a key requests attention only when detection is done and fields valid.
package kss_pkg;

    // clock and scanning clock
    localparam int CLK_NS        = 25;
    localparam int SCLK_NS       = 354;
    localparam int SCLK_CYC      = SCLK_NS / CLK_NS;
    localparam int KBD_NS        = 1400;
    localparam int IO_NS         = 4300;
    localparam int KBD_TICKS     = (KBD_NS + SCLK_NS / 2) / SCLK_NS;
    localparam int IO_TICKS      = (IO_NS + SCLK_NS / 2) / SCLK_NS;
    localparam int SLOT_TICKS    = KBD_TICKS + IO_TICKS;
    localparam int KBD_CYC       = KBD_TICKS * SCLK_CYC;
    localparam int SLOT_CYC      = SLOT_TICKS * SCLK_CYC;

    // sampling points, in clock cycles from the start of a row slot
    localparam int SYNC_LAT      = 3;
    localparam int KEY_VALID_NS  = 1200;
    localparam int KEY_CAP_CYC   = (KEY_VALID_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
    localparam int KEY_PROC_CYC  = KEY_CAP_CYC + 1;
    localparam int SW_VALID_NS   = 4000;
    localparam int SW_CAP_CYC    = KBD_CYC + (SW_VALID_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
    localparam int SH_FOLLOW_NS  = 1000;
    localparam int SH_FOLLOW_CYC = (SH_FOLLOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int SH_HOLD_NS    = 2200;
    localparam int SH_HOLD_CYC   = SH_HOLD_NS / CLK_NS;
    localparam int LED_GUARD_NS  = 177;
    localparam int LED_GUARD_CYC = (LED_GUARD_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADC_STORE_CYC = SLOT_CYC - 2;

    // matrix geometry
    localparam int KEY_COLS      = 11;
    localparam int LINE_W        = 11;
    localparam int ADC_W         = 8;
    localparam int RAM_AW        = 7;
    localparam int RAM_DW        = 16;

    // shared RAM map
    localparam logic [6:0] LED_BASE = 7'h58;
    localparam logic [6:0] SW_BASE  = 7'h60;
    localparam logic [6:0] ADC_BASE = 7'h70;

    // key entry layout
    localparam int SRQ_BIT       = 10;
    localparam int ON_BIT        = 9;
    localparam int BUSY_BIT      = 8;
    localparam logic [7:0] TIME_MAX = 8'hFF;

    // bus map, byte addresses; RAM words sit at 0x000..0x1FC
    localparam int WB_AW         = 10;
    localparam logic [9:0] STATUS_OFS = 10'h200;
    localparam logic [9:0] CONFIG_OFS = 10'h204;
    localparam logic [1:0] CFG_RST    = 2'h0;
    localparam int STAT_REQ_BIT  = 7;
    localparam int STAT_SW_BIT   = 8;

endpackage

// *** verification/kss_kbd_model.sv ***
`timescale 1ns/1ps
module kss_kbd_model
    import kss_pkg::*;
(
    // scan lines from the scanner
    input  wire logic              phase_i,
    input  wire logic [2:0]        row_i,
    input  wire logic              row_hi_i,
    input  wire logic [LINE_W-1:0] led_i,
    input  wire logic [LINE_W-1:0] led_oe_i,
    // stimulus
    input  wire logic [3:0]        col_i,
    input  wire logic [2:0]        key_row_i,
    input  wire logic              brk_on_i,
    input  wire logic              mk_on_i,
    input  wire logic [3:0]        sw_row_i,
    input  wire logic [LINE_W-1:0] sw_bits_i,
    // lines into the scanner, active low with pull-ups
    output logic      [LINE_W-1:0] brk_o,
    output logic      [LINE_W-1:0] mk_o
);
    logic [LINE_W-1:0] key_mk;
    always_comb begin
        brk_o = '1;
        key_mk = '1;
        if (phase_i && row_i == key_row_i) begin
            brk_o[col_i] = ~brk_on_i;
            key_mk[col_i] = ~mk_on_i;
        end else if (!phase_i && {row_hi_i, row_i} == sw_row_i) begin
            brk_o = ~sw_bits_i;
        end
    end
    // scanner drive wins where enabled, key contact or pull-up elsewhere
    assign mk_o = (led_oe_i & led_i) | (~led_oe_i & key_mk);
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb
    import kss_pkg::*;
;
    typedef struct packed {logic we; logic [9:0] adr; logic [3:0] sel; logic [15:0] d;} kss_row_t;
    logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic              phase, row_hi, sh, req, sw_ev, brk_on, mk_on;
    logic [WB_AW-1:0]  wb_adr_i;
    logic [3:0]        wb_sel_i, col, sw_row;
    logic [31:0]       wb_dat_i, wb_dat_o, rd;
    logic [2:0]        row, key_row, r0;
    logic [LINE_W-1:0] mk_i, led, led_oe, brk_i, sw_bits;
    int                failures, compares, cyc, t, hi, shr, shf;
    kss_row_t          tbl [8] = '{'{1'b1, 10'h16C, 4'h3, 16'h05A5},
        '{1'b0, 10'h16C, 4'hF, 16'h05A5},
        '{1'b1, 10'h16C, 4'h1, 16'h00F0}, '{1'b0, 10'h16C, 4'hF, 16'h05F0},
        '{1'b1, 10'h16C, 4'h2, 16'h0300}, '{1'b0, 10'h16C, 4'hF, 16'h03F0},
        '{1'b1, 10'h20C, 4'hF, 16'hFFFF}, '{1'b0, 10'h20C, 4'hF, 16'h0000}};

    kss_scanner dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scan_phase_select_o(phase), .row_o(row),
        .row_hi_o(row_hi), .make_contact_line_i(mk_i), .make_contact_line_o(led),
        .make_contact_line_oe_o(led_oe), .break_contact_line_i(brk_i),
        .adc_data_i({4'hA, row_hi, row}),
        .sh_follow_o(sh), .key_service_request_o(req), .switch_event_o(sw_ev));
    kss_kbd_model kbd_u (.phase_i(phase), .row_i(row), .row_hi_i(row_hi), .led_i(led),
        .led_oe_i(led_oe), .col_i(col), .key_row_i(key_row), .brk_on_i(brk_on), .mk_on_i(mk_on),
        .sw_row_i(sw_row), .sw_bits_i(sw_bits), .brk_o(brk_i), .mk_o(mk_i));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures = failures + 1;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle; ack and read data are taken at the rising edge that sees ack high
    task automatic wb(input logic we, input logic [9:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wait_req();
        while (req !== 1'b1) begin
            @(negedge clk_i);
        end
        wb(1'b0, STATUS_OFS, 4'hF, 32'h0);
    endtask

    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, brk_on, mk_on} = 5'h00;
        {wb_adr_i, wb_sel_i, wb_dat_i, col, key_row, sw_row, sw_bits} = '0;
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        chk({phase, row, row_hi, sh, req, sw_ev, wb_ack_o, led_oe, led}, 32'h4000_0000);
        chk(wb_dat_o, 32'h0);
        @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 128; i++) wb(1'b1, 10'(i * 4), 4'h3, 32'h0);
        foreach (tbl[i]) begin
            wb(tbl[i].we, tbl[i].adr, tbl[i].sel, {16'h0, tbl[i].d});
            if (!tbl[i].we) chk({16'h0, rd[15:0]}, {16'h0, tbl[i].d});
        end
        // one slot: phase widths, row step, sample-and-hold window
        while (phase !== 1'b0) @(negedge clk_i);
        while (phase !== 1'b1) @(negedge clk_i);
        {t, hi, shr, shf} = {32'd0, 32'd0, -32'sd1, -32'sd1};
        r0 = row;
        do begin
            if (phase === 1'b1) hi++;
            if (sh === 1'b1 && shr < 0) shr = t;
            if (sh === 1'b0 && shr >= 0 && shf < 0) shf = t;
            @(negedge clk_i);
            t++;
        end while (!(phase === 1'b1 && t > 60) && t < 400);
        chk(32'(hi), 32'(KBD_CYC));
        chk(32'(t - hi), 32'(SLOT_CYC - KBD_CYC));
        chk(32'(row), 32'(3'(r0 + 3'h1)));
        chk(32'(shr >= SH_FOLLOW_CYC && shf <= SH_HOLD_CYC && shf > shr), 32'h1);
        while (!(row === 3'h3 && led_oe === 11'h7FF)) @(negedge clk_i);
        chk(32'(led), 32'h03F0);
        // switch change on row 2
        repeat (3600) @(posedge clk_i);
        wb(1'b1, STATUS_OFS, 4'h2, 32'h100);
        // converter input follows the row, so row 5 must hold 0xA5
        wb(1'b0, {ADC_BASE | 7'h05, 2'h0}, 4'hF, 32'h0);
        chk(32'(rd[7:0]), 32'hA5);
        chk(32'(sw_ev), 32'h0);
        sw_row <= 4'h2;
        sw_bits <= 11'h001;
        while (sw_ev !== 1'b1) begin
            @(negedge clk_i);
        end
        wb(1'b0, STATUS_OFS, 4'hF, 32'h0);
        chk(32'(rd[12:8]), 32'h05);
        // key on at column 2, row 1: entry 0x11
        col <= 4'h2;
        key_row <= 3'h1;
        brk_on <= 1'b1;
        repeat (4000) @(posedge clk_i);
        mk_on <= 1'b1;
        wait_req();
        chk(32'(rd[7:0]), 32'h91);
        wb(1'b0, 10'h044, 4'hF, 32'h0);
        chk(32'(rd[10:8]), 32'h6);
        chk(32'(rd[7:0] >= 8'h01 && rd[7:0] <= 8'h02), 32'h1);
        // clear attention but keep the on bit so the key stays held
        wb(1'b1, 10'h044, 4'h2, 32'h0000_0200);
        chk(32'(req), 32'h0);
        // key off
        mk_on <= 1'b0;
        repeat (2000) @(posedge clk_i);
        brk_on <= 1'b0;
        wait_req();
        wb(1'b0, 10'h044, 4'hF, 32'h0);
        chk(32'(rd[10:8]), 32'h4);
        report_and_stop();
    end
endmodule

// *** verilog/kss_dpram.sv ***
`timescale 1ns/1ps
module kss_dpram #(
    parameter int AW = 7,
    parameter int DW = 16
) (
    // clock
    input  wire logic          clk_i,
    // port a, byte enables
    input  wire logic [AW-1:0] a_addr_i,
    input  wire logic          a_we_i,
    input  wire logic [1:0]    a_be_i,
    input  wire logic [DW-1:0] a_wdata_i,
    output logic      [DW-1:0] a_rdata_o,
    // port b, whole words
    input  wire logic [AW-1:0] b_addr_i,
    input  wire logic          b_we_i,
    input  wire logic [DW-1:0] b_wdata_i,
    output logic      [DW-1:0] b_rdata_o
);

    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    // reads return the old word; on a same-word write port a lands last and wins in its enabled bytes
    always_ff @(posedge clk_i) begin
        a_rdata_o <= mem_r[a_addr_i];
        b_rdata_o <= mem_r[b_addr_i];
        if (b_we_i) begin
            mem_r[b_addr_i] <= b_wdata_i;
        end
        if (a_we_i && a_be_i[0]) begin
            mem_r[a_addr_i][DW/2-1:0] <= a_wdata_i[DW/2-1:0];
        end
        if (a_we_i && a_be_i[1]) begin
            mem_r[a_addr_i][DW-1:DW/2] <= a_wdata_i[DW-1:DW/2];
        end
    end

endmodule

// *** verilog/kss_scanner.sv ***
`timescale 1ns/1ps
module kss_scanner
    import kss_pkg::*;
(
    // system
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [WB_AW-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // matrix
    output logic                   scan_phase_select_o,
    output logic      [2:0]        row_o,
    output logic                   row_hi_o,
    input  wire logic [LINE_W-1:0] make_contact_line_i,
    output logic      [LINE_W-1:0] make_contact_line_o,
    output logic      [LINE_W-1:0] make_contact_line_oe_o,
    input  wire logic [LINE_W-1:0] break_contact_line_i,
    // converter
    input  wire logic [ADC_W-1:0]  adc_data_i,
    output logic                   sh_follow_o,
    // events
    output logic                   key_service_request_o,
    output logic                   switch_event_o
);

    localparam int SYN_W = ADC_W + 2 * LINE_W;

    logic [3:0]        div_r, div_nxt, tick_r, tick_nxt, row_r, row_nxt;
    logic [2:0]        frame_r;
    logic [7:0]        pos, pos_nxt;
    logic              phase_r, follow_r;
    logic [LINE_W-1:0] led_r, mk_out_r, mk_oe_r;
    logic [SYN_W-1:0]  syn1_r, syn2_r, syn3_r, filt_r;
    logic [LINE_W-1:0] mk_cl, br_cl, key_mk_r, key_br_r, sw_r;
    logic [1:0]        cfg_r;
    logic [3:0]        col;
    logic              key_win, key_wr, sw_wr, skip, key_set;
    logic [6:0]        b_addr;
    logic              b_we;
    logic [15:0]       b_wdata, b_rdata, key_new;
    logic              req_r, req_clr, sw_ev_r;
    logic [6:0]        req_key_r;
    logic [3:0]        sw_row_r;
    logic              stage_r, ack_r, wb_req, a_we, a_we_q_r;
    logic [6:0]        a_addr, a_addr_q_r;
    logic [15:0]       a_rdata;
    logic [31:0]       dat_r, rd_mux;
    logic              wr_status, wr_config;

    function automatic logic [7:0] kss_pos(input logic [3:0] tick, input logic [3:0] div);
        kss_pos = 8'(tick * SCLK_CYC) + 8'(div);
    endfunction

    function automatic logic [LINE_W-1:0] kss_closed(input logic [LINE_W-1:0] v,
                                                     input logic act_high);
        kss_closed = act_high ? v : ~v;
    endfunction

    // interval prescale grows with the count: pseudo-log time base
    function automatic logic [7:0] kss_time_step(input logic [7:0] t, input logic [2:0] fr);
        logic step;
        step = (t < 8'h40) | ((t < 8'h80) & ~fr[0]) | ((t < 8'hC0) & (fr[1:0] == 2'h0))
             | (fr == 3'h0);
        kss_time_step = (t == TIME_MAX || !step) ? t : t + 8'h01;
    endfunction

    // key entry update: break contact closes first on press, make contact second
    function automatic logic [15:0] kss_key_next(input logic [15:0] e, input logic mk,
                                                 input logic br, input logic [2:0] fr);
        logic       on, busy, key_attention_flag;
        logic [7:0] t;
        on   = e[ON_BIT];
        busy = e[BUSY_BIT];
        key_attention_flag  = e[SRQ_BIT];
        t    = e[7:0];
        if (!busy) begin
            if ((!on && br) || (on && !mk)) begin
                busy = 1'b1;
                key_attention_flag  = 1'b0;
                t    = 8'h00;
            end
        end else if (!on) begin
            if (mk) begin
                on   = 1'b1;
                busy = 1'b0;
                key_attention_flag  = 1'b1;
            end else if (!br) begin
                busy = 1'b0;
                t    = 8'h00;
            end else begin
                t = kss_time_step(t, fr);
            end
        end else begin
            if (!br) begin
                on   = 1'b0;
                busy = 1'b0;
                key_attention_flag  = 1'b1;
            end else if (mk) begin
                busy = 1'b0;
            end else begin
                t = kss_time_step(t, fr);
            end
        end
        kss_key_next           = 16'h0000;
        kss_key_next[7:0]      = t;
        kss_key_next[BUSY_BIT] = busy;
        kss_key_next[ON_BIT]   = on;
        kss_key_next[SRQ_BIT]  = key_attention_flag;
    endfunction

    // scanning clock divider, tick and row counters
    always_comb begin
        div_nxt  = (div_r == 4'(SCLK_CYC - 1)) ? 4'h0 : div_r + 4'h1;
        tick_nxt = tick_r;
        row_nxt  = row_r;
        if (div_r == 4'(SCLK_CYC - 1)) begin
            if (tick_r == 4'(SLOT_TICKS - 1)) begin
                tick_nxt = 4'h0;
                row_nxt  = row_r + 4'h1;
            end else begin
                tick_nxt = tick_r + 4'h1;
            end
        end
    end

    assign pos     = kss_pos(tick_r, div_r);
    assign pos_nxt = kss_pos(tick_nxt, div_nxt);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r    <= 4'h0;
            tick_r   <= 4'h0;
            row_r    <= 4'h0;
            frame_r  <= 3'h0;
            phase_r  <= 1'b1;
            follow_r <= 1'b0;
        end else begin
            div_r    <= div_nxt;
            tick_r   <= tick_nxt;
            row_r    <= row_nxt;
            if (row_nxt[2:0] == 3'h0 && row_r[2:0] == 3'h7) begin
                frame_r <= frame_r + 3'h1;
            end
            phase_r  <= pos_nxt < 8'(KBD_CYC);
            follow_r <= pos_nxt >= 8'(SH_FOLLOW_CYC) &&
                        pos_nxt < 8'(SH_HOLD_CYC);
        end
    end

    // LED drive on the make lines during the switch phase, after a guard time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_r    <= '0;
            mk_out_r <= '0;
            mk_oe_r  <= '0;
        end else begin
            if (pos == 8'h01) begin
                led_r <= b_rdata[LINE_W-1:0];
            end
            mk_out_r <= cfg_r[1] ? ~led_r : led_r;
            mk_oe_r  <= (pos_nxt >= 8'(KBD_CYC + LED_GUARD_CYC)) ? '1 : '0;
        end
    end

    // three-stage pin synchroniser; a bit moves once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            syn1_r <= '0;
            syn2_r <= '0;
            syn3_r <= '0;
            filt_r <= '0;
        end else begin
            syn1_r <= {adc_data_i, break_contact_line_i, make_contact_line_i};
            syn2_r <= syn1_r;
            syn3_r <= syn2_r;
            filt_r <= (syn3_r & ~(syn2_r ^ syn3_r)) | (filt_r & (syn2_r ^ syn3_r));
        end
    end

    assign mk_cl = kss_closed(filt_r[LINE_W-1:0], cfg_r[0]);
    assign br_cl = kss_closed(filt_r[2*LINE_W-1:LINE_W], cfg_r[0]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_mk_r <= '0;
            key_br_r <= '0;
            sw_r     <= '0;
        end else begin
            if (pos == 8'(KEY_CAP_CYC)) begin
                key_mk_r <= mk_cl;
                key_br_r <= br_cl;
            end
            if (pos == 8'(SW_CAP_CYC)) begin
                sw_r <= br_cl;
            end
        end
    end

    // scanner port of the shared RAM: fixed time slots within each row
    assign key_win = pos >= 8'(KEY_PROC_CYC) && pos < 8'(KEY_PROC_CYC + 2 * KEY_COLS);
    assign col     = 4'((pos - 8'(KEY_PROC_CYC)) >> 1);
    assign key_new = kss_key_next(b_rdata, key_mk_r[col], key_br_r[col], frame_r);
    assign skip    = (a_we && a_addr == b_addr) || (a_we_q_r && a_addr_q_r == b_addr);

    always_comb begin
        b_addr  = LED_BASE | {4'h0, row_r[2:0]};
        b_we    = 1'b0;
        b_wdata = 16'h0000;
        key_wr  = 1'b0;
        sw_wr   = 1'b0;
        if (key_win) begin
            b_addr = {col[3:0], row_r[2:0]};
            if (pos[0] != 1'(KEY_PROC_CYC)) begin
                key_wr  = !skip;
                b_we    = key_wr;
                b_wdata = key_new;
            end
        end else if (pos == 8'(SW_CAP_CYC)) begin
            b_addr = SW_BASE | {3'h0, row_r};
        end else if (pos == 8'(SW_CAP_CYC + 1)) begin
            b_addr  = SW_BASE | {3'h0, row_r};
            sw_wr   = (b_rdata[LINE_W-1:0] != sw_r) && !skip;
            b_we    = sw_wr;
            b_wdata = {5'h00, sw_r};
        end else if (pos == 8'(ADC_STORE_CYC)) begin
            b_addr  = ADC_BASE | {3'h0, row_r};
            b_we    = 1'b1;
            b_wdata = {8'h00, filt_r[SYN_W-1:2*LINE_W]};
        end
    end

    kss_dpram #(
        .AW (RAM_AW),
        .DW (RAM_DW)
    ) u_ram (
        .clk_i     (clk_i),
        .a_addr_i  (a_addr),
        .a_we_i    (a_we),
        .a_be_i    (wb_sel_i[1:0]),
        .a_wdata_i (wb_dat_i[15:0]),
        .a_rdata_o (a_rdata),
        .b_addr_i  (b_addr),
        .b_we_i    (b_we),
        .b_wdata_i (b_wdata),
        .b_rdata_o (b_rdata)
    );

    // key service request: one key at a time, new finish wins over a clear
    assign req_clr = req_r && a_we && wb_sel_i[1] && a_addr == req_key_r;
    assign key_set = key_wr && key_new[SRQ_BIT] && (!req_r || req_clr);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_r     <= 1'b0;
            req_key_r <= 7'h00;
        end else if (key_set) begin
            req_r     <= 1'b1;
            req_key_r <= b_addr;
        end else if (req_clr) begin
            req_r     <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_ev_r  <= 1'b0;
            sw_row_r <= 4'h0;
        end else if (sw_wr) begin
            sw_ev_r  <= 1'b1;
            sw_row_r <= row_r;
        end else if (wr_status && wb_sel_i[1] && wb_dat_i[STAT_SW_BIT]) begin
            sw_ev_r  <= 1'b0;
        end
    end

    // wishbone slave: request taken, RAM read, then ack with registered data
    assign wb_req    = wb_cyc_i && wb_stb_i && !ack_r && !stage_r;
    assign a_addr    = wb_adr_i[8:2];
    assign a_we      = stage_r && wb_we_i && !wb_adr_i[9];
    assign wr_status = stage_r && wb_we_i && wb_adr_i[WB_AW-1:2] == STATUS_OFS[WB_AW-1:2];
    assign wr_config = stage_r && wb_we_i && wb_adr_i[WB_AW-1:2] == CONFIG_OFS[WB_AW-1:2];

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (!wb_adr_i[9]) begin
            rd_mux = {16'h0000, a_rdata};
        end else if (wb_adr_i[WB_AW-1:2] == STATUS_OFS[WB_AW-1:2]) begin
            rd_mux = {19'h0, sw_row_r, sw_ev_r, req_r, req_key_r};
        end else if (wb_adr_i[WB_AW-1:2] == CONFIG_OFS[WB_AW-1:2]) begin
            rd_mux = {30'h0, cfg_r};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_r    <= 1'b0;
            ack_r      <= 1'b0;
            dat_r      <= 32'h0000_0000;
            cfg_r      <= CFG_RST;
            a_we_q_r   <= 1'b0;
            a_addr_q_r <= 7'h00;
        end else begin
            stage_r    <= wb_req;
            ack_r      <= stage_r;
            a_we_q_r   <= a_we;
            a_addr_q_r <= a_addr;
            if (stage_r) begin
                dat_r <= rd_mux;
            end
            if (wr_config && wb_sel_i[0]) begin
                cfg_r <= wb_dat_i[1:0];
            end
        end
    end

    assign wb_dat_o               = dat_r;
    assign wb_ack_o               = ack_r;
    assign scan_phase_select_o    = phase_r;
    assign row_o                  = row_r[2:0];
    assign row_hi_o               = row_r[3];
    assign make_contact_line_o    = mk_out_r;
    assign make_contact_line_oe_o = mk_oe_r;
    assign sh_follow_o            = follow_r;
    assign key_service_request_o  = req_r;
    assign switch_event_o         = sw_ev_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_kbd_high_time: assert property ($rose(phase_r) |-> ##55 phase_r ##1 !phase_r)
        else $error("phase select high time wrong");
    a_io_low_time: assert property ($fell(phase_r) |-> ##167 !phase_r ##1 phase_r)
        else $error("phase select low time wrong");
    a_row_step: assert property ($changed(row_r) |->
        row_r == $past(row_r) + 4'h1 && $rose(phase_r))
        else $error("row did not step with phase rise");
    a_sclk_tick: assert property ($changed(tick_r) |-> $past(div_r) == 4'(SCLK_CYC - 1))
        else $error("tick moved off the scanning clock");
    a_follow_late: assert property ($rose(follow_r) |-> $past(row_r, 40) == row_r)
        else $error("follow mode too soon after row change");
    a_hold_early: assert property ($changed(row_r) |-> ##88 !follow_r)
        else $error("hold mode too late");
    a_key_capture: assert property (pos == 8'(KEY_CAP_CYC) |-> phase_r &&
        $past(phase_r, 51) && (!$past(phase_r, 52) || $past(rst_i, 52)))
        else $error("key capture at wrong time");
    a_sw_capture: assert property (pos == 8'(SW_CAP_CYC) |-> !phase_r &&
        !$past(phase_r, 163) && $past(phase_r, 164))
        else $error("switch capture at wrong time");
    a_led_guard: assert property (mk_oe_r != '0 |-> !phase_r && !$past(phase_r, 8))
        else $error("led drive inside key phase or guard");
    a_req_clear: assert property (req_clr && !key_set |=> !req_r)
        else $error("key request not cleared by upper byte write");
    a_req_single: assert property (req_r && !req_clr |=> req_r && $stable(req_key_r))
        else $error("key request changed while pending");
    a_srq_done: assert property (key_wr && b_wdata[SRQ_BIT] |-> !b_wdata[BUSY_BIT])
        else $error("attention set while detection busy");
    a_time_sat: assert property (key_wr && b_rdata[BUSY_BIT] && b_wdata[BUSY_BIT] &&
        b_rdata[7:0] == TIME_MAX |-> b_wdata[7:0] == TIME_MAX)
        else $error("interval count wrapped");
    a_wb_latency: assert property (wb_req |-> ##2 ack_r ##1 !ack_r)
        else $error("bus answer latency wrong");
    a_adc_store: assert property (pos == 8'(ADC_STORE_CYC) |-> b_we && b_addr[6:4] == 3'h7)
        else $error("converter value not stored");
    a_sw_event: assert property (sw_wr |=> sw_ev_r)
        else $error("switch change not flagged");

    c_key_request: cover property (key_set);
    c_key_clear: cover property (req_clr);
    c_sw_change: cover property (sw_wr);
    c_ram_write: cover property (a_we && wb_sel_i[1:0] == 2'h3);

endmodule
